// >>> hw/ursc_rx_ctrl.sv
// receive status and control logic of a serial port
`timescale 1ns/1ps
`default_nettype none

module ursc_rx_ctrl
	import ursc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// mode from the transmit side
	input wire logic syncMode,
	input wire logic syncMaster,
	// character from the shift datapath
	input wire ursc_char_s rxChar,
	// controls to the datapath and pins
	output logic receiveEnable,
	output logic portEnable,
	output logic nineBitMode,
	output logic addressDetectOn,
	output logic intReq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ursc_ctrl_s ctrl_ff;
	ursc_ctrl_s nxt_ctrl;
	logic [7:0] rxBuf_ff;
	logic [7:0] nxt_rxBuf;
	logic bufFull_ff;
	logic nxt_bufFull;
	logic frameErr_ff;
	logic nxt_frameErr;
	logic overrun_ff;
	logic nxt_overrun;
	logic ninthBit_ff;
	logic nxt_ninthBit;
	logic [2:0] irqStat_ff;
	logic [2:0] nxt_irqStat;
	logic [2:0] irqMask_ff;
	logic [2:0] nxt_irqMask;
	logic [7:0] rdData_ff;
	logic [7:0] nxt_rdData;
	logic rxEn_ff;
	logic nxt_rxEn;
	logic irq_ff;
	logic nxt_irq;

	// ------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------
	// one strobe qualified by one register index
	function automatic logic regHit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] idx);
		return strobe && (addr == idx);
	endfunction

	wire logic wrCtrl = regHit(regWrite, regAddr, URSC_ADDR_CTRL);
	wire logic wrMask = regHit(regWrite, regAddr, URSC_ADDR_IMASK);
	wire logic rdData = regHit(regRead, regAddr, URSC_ADDR_DATA);
	wire logic rdStat = regHit(regRead, regAddr, URSC_ADDR_ISTAT);

	// status view of the control register, placed by field position
	logic [7:0] ctrlView;
	always_comb begin
		ctrlView = URSC_RST_BYTE;
		ctrlView[URSC_BIT_PORT_EN] = ctrl_ff.serialPortEnable;
		ctrlView[URSC_BIT_NINE_SEL] = ctrl_ff.nineBitReceiveSelect;
		ctrlView[URSC_BIT_SINGLE_EN] = ctrl_ff.singleReceiveEnable;
		ctrlView[URSC_BIT_CONT_EN] = ctrl_ff.continuousReceiveEnable;
		ctrlView[URSC_BIT_ADDR_DET] = ctrl_ff.addressDetectEnable;
		ctrlView[URSC_BIT_FRAME_ERR] = frameErr_ff;
		ctrlView[URSC_BIT_OVERRUN] = overrun_ff;
		ctrlView[URSC_BIT_NINTH] = ninthBit_ff;
	end

	// ------------------------------------------------------------
	// receiver enable
	// ------------------------------------------------------------
	wire logic masterSync = syncMode && syncMaster;
	wire logic contOn = ctrl_ff.continuousReceiveEnable;
	// single receive in sync master only
	wire logic singleOn = masterSync && ctrl_ff.singleReceiveEnable && !contOn;
	// overrun blocks reception until it is cleared, so no later byte hides it
	wire logic rxOn = ctrl_ff.serialPortEnable && (contOn || singleOn) && !overrun_ff;

	// ------------------------------------------------------------
	// character acceptance
	// ------------------------------------------------------------
	// address detect in async nine-bit only
	wire logic addrMode = !syncMode && ctrl_ff.nineBitReceiveSelect &&
		ctrl_ff.addressDetectEnable;
	wire logic charIn = rxChar.valid && rxEn_ff;
	wire logic charKeep = charIn && !(addrMode && !rxChar.ninth);
	// buffer is emptied by the read in the same cycle, so the new byte still fits
	wire logic bufFree = !bufFull_ff || rdData;
	wire logic charLoad = charKeep && bufFree;
	wire logic charLost = charKeep && !bufFree;

	// ------------------------------------------------------------
	// control register next value
	// ------------------------------------------------------------
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wrCtrl) begin
			nxt_ctrl.serialPortEnable = regWrData[URSC_BIT_PORT_EN];
			nxt_ctrl.nineBitReceiveSelect = regWrData[URSC_BIT_NINE_SEL];
			nxt_ctrl.singleReceiveEnable = regWrData[URSC_BIT_SINGLE_EN];
			nxt_ctrl.continuousReceiveEnable = regWrData[URSC_BIT_CONT_EN];
			nxt_ctrl.addressDetectEnable = regWrData[URSC_BIT_ADDR_DET];
		end else if (singleOn && charIn) begin
			nxt_ctrl.singleReceiveEnable = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// receive buffer and status flags
	// ------------------------------------------------------------
	assign nxt_rxBuf = charLoad ? rxChar.data : rxBuf_ff;
	assign nxt_bufFull = charLoad || (bufFull_ff && !rdData);
	assign nxt_frameErr = charLoad ? rxChar.frameErr : frameErr_ff;
	// ninth bit kept only in nine-bit mode
	assign nxt_ninthBit = (charLoad && ctrl_ff.nineBitReceiveSelect) ? rxChar.ninth : ninthBit_ff;
	wire logic contCleared = wrCtrl && !regWrData[URSC_BIT_CONT_EN];
	assign nxt_overrun = charLost || (overrun_ff && !contCleared);

	// ------------------------------------------------------------
	// interrupt status, mask and request
	// ------------------------------------------------------------
	logic [2:0] irqEvent;
	always_comb begin
		irqEvent = URSC_RST_IRQ;
		irqEvent[URSC_IRQ_RXRDY] = charLoad;
		irqEvent[URSC_IRQ_FRAME] = charLoad && rxChar.frameErr;
		irqEvent[URSC_IRQ_OVER] = charLost;
	end
	// a read clears, but an event in the same cycle is kept
	assign nxt_irqStat = irqEvent | (rdStat ? URSC_RST_IRQ : irqStat_ff);
	assign nxt_irqMask = wrMask ? regWrData[2:0] : irqMask_ff;
	assign nxt_irq = |(nxt_irqStat & nxt_irqMask);

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	always_comb begin
		nxt_rdData = URSC_RST_BYTE;
		if (regRead) begin
			unique case (regAddr)
				URSC_ADDR_CTRL: nxt_rdData = ctrlView;
				URSC_ADDR_DATA: nxt_rdData = rxBuf_ff;
				URSC_ADDR_ISTAT: nxt_rdData = {5'h00, irqStat_ff};
				URSC_ADDR_IMASK: nxt_rdData = {5'h00, irqMask_ff};
				default: nxt_rdData = URSC_RST_BYTE;
			endcase
		end
	end

	assign nxt_rxEn = rxOn;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= URSC_RST_CTRL;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ------------------------------------------------------------
	// receive buffer
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rxBuf_ff <= URSC_RST_BYTE;
		end else begin
			rxBuf_ff <= nxt_rxBuf;
		end
	end

	// a load in the cycle of a data read keeps the buffer full
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bufFull_ff <= URSC_RST_BIT;
		end else begin
			bufFull_ff <= nxt_bufFull;
		end
	end

	// ------------------------------------------------------------
	// receive flags
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			frameErr_ff <= URSC_RST_BIT;
		end else begin
			frameErr_ff <= nxt_frameErr;
		end
	end

	// sticky: only a write that drops continuous receive lets it go
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			overrun_ff <= URSC_RST_BIT;
		end else begin
			overrun_ff <= nxt_overrun;
		end
	end

	// reset to zero rather than unknown so a read never shows an undefined bit
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ninthBit_ff <= URSC_RST_BIT;
		end else begin
			ninthBit_ff <= nxt_ninthBit;
		end
	end

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irqStat_ff <= URSC_RST_IRQ;
		end else begin
			irqStat_ff <= nxt_irqStat;
		end
	end

	// ------------------------------------------------------------
	// interrupt mask and request
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irqMask_ff <= URSC_RST_IRQ;
		end else begin
			irqMask_ff <= nxt_irqMask;
		end
	end

	// built from next status and mask so request and status bit rise together
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_ff <= URSC_RST_BIT;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// zero outside the answer cycle, so a stale value never looks like a read
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdData_ff <= URSC_RST_BYTE;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	// ------------------------------------------------------------
	// receiver enable
	// ------------------------------------------------------------
	// one cycle behind the control bits; the datapath sees a clean level
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rxEn_ff <= URSC_RST_BIT;
		end else begin
			rxEn_ff <= nxt_rxEn;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign regRdData = rdData_ff;
	assign receiveEnable = rxEn_ff;
	assign portEnable = ctrl_ff.serialPortEnable;
	assign nineBitMode = ctrl_ff.nineBitReceiveSelect;
	assign addressDetectOn = ctrl_ff.addressDetectEnable;
	assign intReq = irq_ff;

endmodule

`default_nettype wire

// >>> inc/ursc_pkg.sv
// constants and types shared by the receive status and control block
package ursc_pkg;

	// ------------------------------------------------------------
	// register map (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] URSC_ADDR_CTRL = 4'h0;
	localparam logic [3:0] URSC_ADDR_DATA = 4'h1;
	localparam logic [3:0] URSC_ADDR_ISTAT = 4'h2;
	localparam logic [3:0] URSC_ADDR_IMASK = 4'h3;

	// ------------------------------------------------------------
	// receive_status_control field positions
	// ------------------------------------------------------------
	localparam int URSC_BIT_PORT_EN = 7;
	localparam int URSC_BIT_NINE_SEL = 6;
	localparam int URSC_BIT_SINGLE_EN = 5;
	localparam int URSC_BIT_CONT_EN = 4;
	localparam int URSC_BIT_ADDR_DET = 3;
	localparam int URSC_BIT_FRAME_ERR = 2;
	localparam int URSC_BIT_OVERRUN = 1;
	localparam int URSC_BIT_NINTH = 0;

	// ------------------------------------------------------------
	// interrupt status and mask field positions
	// ------------------------------------------------------------
	localparam int URSC_IRQ_RXRDY = 0;
	localparam int URSC_IRQ_FRAME = 1;
	localparam int URSC_IRQ_OVER = 2;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] URSC_RST_BYTE = 8'h00;
	localparam logic URSC_RST_BIT = 1'b0;
	localparam logic [2:0] URSC_RST_IRQ = 3'h0;

	// software-writable control bits (upper five) of the register
	typedef struct packed {
		logic serialPortEnable;
		logic nineBitReceiveSelect;
		logic singleReceiveEnable;
		logic continuousReceiveEnable;
		logic addressDetectEnable;
	} ursc_ctrl_s;

	// one character handed over by the shift datapath
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic ninth;
		logic frameErr;
	} ursc_char_s;

	localparam ursc_ctrl_s URSC_RST_CTRL = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// >>> sim/ursc_rx_ctrl_assertions.sv
// port assertions for the receive status and control block
`timescale 1ns/1ps
`default_nettype none
module ursc_rx_ctrl_assertions
	import ursc_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire ursc_char_s rxChar,
	input wire logic receiveEnable,
	input wire logic portEnable,
	input wire logic nineBitMode,
	input wire logic addressDetectOn,
	input wire logic intReq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire ctlWr = regWrite && regAddr == URSC_ADDR_CTRL;
	sequence sFrameChar;
		rxChar.valid && receiveEnable && rxChar.frameErr && !addressDetectOn;
	endsequence
	sequence sStatusRead;
		regRead && regAddr == URSC_ADDR_ISTAT;
	endsequence
	sequence sNoStatusRead;
		!(regRead && regAddr == URSC_ADDR_ISTAT);
	endsequence
	AST_RXEN_PORT: assert property (receiveEnable |-> $past(portEnable))
		else $error("receiver on while port off");
	AST_ADDR_DET: assert property (ctlWr |=> addressDetectOn == $past(regWrData[URSC_BIT_ADDR_DET]))
		else $error("address detect not taken from write");
	AST_NINE_SEL: assert property (ctlWr |=> nineBitMode == $past(regWrData[URSC_BIT_NINE_SEL]))
		else $error("nine bit select not taken from write");
	// receiver only drops after a write, a completed single receive or an overrun
	AST_RXEN_FALL: assert property ($fell(receiveEnable) |-> $past(regWrite, 2) || $past(rxChar.valid, 2))
		else $error("receiver dropped without cause");
	// a full buffer turns the framed character into an overrun instead
	AST_FRAME_STAT: assert property (sFrameChar ##1 sNoStatusRead ##1 sStatusRead |=> (regRdData[URSC_IRQ_FRAME] || regRdData[URSC_IRQ_OVER]))
		else $error("framing event missing from status");
	AST_IRQ_CAUSE: assert property ($rose(intReq) |-> $past(rxChar.valid) || $past(regWrite))
		else $error("interrupt rose without event");
endmodule
bind ursc_rx_ctrl ursc_rx_ctrl_assertions u_chk (.*);
`default_nettype wire

// >>> sim/ursc_tx_model.sv
// behavioural remote transmitter handing characters to the receive block
`timescale 1ns/1ps
`default_nettype none
module ursc_tx_model
	import ursc_pkg::*;
(
	input wire logic mclk,
	output var ursc_char_s rxChar
);
	initial rxChar = '0;
	// fields scrambled once the character is gone, so stale data never matches
	task automatic send(input logic [7:0] d, input logic n, input logic fe);
		@(posedge mclk);
		rxChar <= '{1'b1, d, n, fe};
		@(posedge mclk);
		rxChar <= '{1'b0, ~d, ~n, ~fe};
	endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the receive status and control block
`timescale 1ns/1ps
`default_nettype none
module tb
	import ursc_pkg::*;
;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic syncMode = 1'b0;
	logic syncMaster = 1'b0;
	logic [7:0] regRdData;
	logic receiveEnable, portEnable, nineBitMode, addressDetectOn, intReq;
	ursc_char_s rxChar;
	logic [15:0] expQ[$];
	logic [15:0] e;
	logic [15:0] seed = 16'h8888;
	logic [7:0] d0, d1;
	logic rdPend = 1'b0;
	int failures = 0;
	int testsRun = 0;
	always #10 mclk = ~mclk;
	ursc_rx_ctrl u_dut (.*);
	ursc_tx_model u_tx (.*);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// reads note {mask, value}; the monitor below compares one cycle later
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= w;
		regRead <= !w;
		if (!w) expQ.push_back({m, d});
		@(posedge mclk);
		regWrite <= 1'b0;
		regRead <= 1'b0;
	endtask
	always @(posedge mclk) begin
		if (rdPend) begin
			e = expQ.pop_front();
			chk(regRdData & e[15:8], e[7:0] & e[15:8]);
		end
		rdPend <= regRead;
	end
	initial begin
		#20000;
		failures++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		acc(0, URSC_ADDR_CTRL, 8'h00, 8'hFF);
		acc(0, 4'h7, 8'h00, 8'hFF);
		acc(1, URSC_ADDR_CTRL, 8'hA0, 8'hFF);
		repeat (3) @(posedge mclk);
		chk({6'h0, portEnable, receiveEnable}, 8'h02);
		acc(1, URSC_ADDR_IMASK, 8'h07, 8'hFF);
		acc(1, URSC_ADDR_CTRL, 8'h90, 8'hFF);
		repeat (2) @(posedge mclk);
		seed = lfsr(seed);
		d0 = seed[7:0];
		u_tx.send(d0, 1'b0, 1'b1);
		acc(0, URSC_ADDR_ISTAT, 8'h03, 8'h07);
		acc(0, URSC_ADDR_DATA, d0, 8'hFF);
		acc(0, URSC_ADDR_CTRL, 8'h94, 8'hFF);
		seed = lfsr(seed);
		d1 = seed[7:0];
		u_tx.send(d1, 1'b0, 1'b0);
		u_tx.send(~d1, 1'b0, 1'b0);
		repeat (2) @(posedge mclk);
		chk({6'h0, receiveEnable, intReq}, 8'h01);
		acc(0, URSC_ADDR_ISTAT, 8'h05, 8'h07);
		acc(0, URSC_ADDR_CTRL, 8'h92, 8'hFF);
		acc(0, URSC_ADDR_DATA, d1, 8'hFF);
		acc(1, URSC_ADDR_CTRL, 8'h80, 8'hFF);
		acc(0, URSC_ADDR_CTRL, 8'h80, 8'hFF);
		acc(1, URSC_ADDR_IMASK, 8'h00, 8'hFF);
		acc(1, URSC_ADDR_CTRL, 8'hD8, 8'hFF);
		repeat (2) @(posedge mclk);
		u_tx.send(d0, 1'b0, 1'b0);
		u_tx.send(d1, 1'b1, 1'b0);
		repeat (2) @(posedge mclk);
		chk({5'h0, addressDetectOn, nineBitMode, intReq}, 8'h06);
		acc(0, URSC_ADDR_DATA, d1, 8'hFF);
		acc(0, URSC_ADDR_CTRL, 8'hD9, 8'hFF);
		acc(0, URSC_ADDR_ISTAT, 8'h01, 8'h07);
		syncMode <= 1'b1;
		syncMaster <= 1'b1;
		acc(1, URSC_ADDR_CTRL, 8'hA0, 8'hFF);
		repeat (2) @(posedge mclk);
		u_tx.send(d0, 1'b1, 1'b0);
		repeat (2) @(posedge mclk);
		chk({7'h0, receiveEnable}, 8'h00);
		acc(0, URSC_ADDR_CTRL, 8'h80, 8'hFE);
		acc(0, URSC_ADDR_DATA, d0, 8'hFF);
		syncMaster <= 1'b0;
		acc(1, URSC_ADDR_CTRL, 8'hA0, 8'hFF);
		repeat (2) @(posedge mclk);
		u_tx.send(d1, 1'b0, 1'b0);
		repeat (2) @(posedge mclk);
		chk({6'h0, portEnable, receiveEnable}, 8'h02);
		acc(0, URSC_ADDR_CTRL, 8'hA0, 8'hFE);
		repeat (2) @(posedge mclk);
		give_verdict();
	end
endmodule
`default_nettype wire
